// ### rtl/rxf_pkg.sv
// Shared constants for the receive FIFO status-flag block.
package rxf_pkg;
    // Bus widths.
    localparam int AW = 8;
    localparam int DW = 32;
    // Register byte offsets.
    localparam logic [7:0] A_FLAGS = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_CNTL = 8'h08;
    localparam logic [7:0] A_CNTH = 8'h0c;
    localparam logic [7:0] A_CTRL = 8'h10;
    localparam logic [7:0] A_ISTAT = 8'h14;
    localparam logic [7:0] A_IMASK = 8'h18;
    // Bit positions in receive_fifo_flags.
    localparam int B_OVF = 0;
    localparam int B_URF = 1;
    localparam int B_FULL = 2;
    localparam int B_EMP = 3;
    localparam int B_FLUSH = 4;
    localparam int B_CNT = 6;
    // Bit positions in rx_control_register.
    localparam int C_REL = 0;
    localparam int C_CLR = 1;
    localparam int C_ISO = 2;
    localparam int C_FEAT = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Interrupt event bits.
    localparam int N_EV = 3;
    localparam int E_SET = 0;
    localparam int E_FLUSH = 1;
    localparam int E_URF = 2;
    localparam logic [2:0] EV_RST = 3'h0;
    // Data-set count values.
    localparam logic [1:0] CNT_ZERO = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] CNT_MAX = 2'h2;
    // Default size of one data set, in bytes.
    localparam int FIFO_SIZE_DEF = 64;
endpackage : rxf_pkg

// ### rtl/rxf_irq_if.sv
// Interface between the flag logic and the interrupt status unit.
`timescale 1ns/1ps
interface rxf_irq_if;
    // Event pulses from the flag logic.
    logic [rxf_pkg::N_EV-1:0] ev;
    // Register write strobes and data.
    logic wr_stat;
    logic wr_mask;
    logic [rxf_pkg::N_EV-1:0] wdata;
    // Register contents and interrupt level.
    logic [rxf_pkg::N_EV-1:0] stat;
    logic [rxf_pkg::N_EV-1:0] mask;
    logic irq;
    modport core_side (output ev, output wr_stat, output wr_mask, output wdata,
        input stat, input mask, input irq);
    modport irq_side (input ev, input wr_stat, input wr_mask, input wdata,
        output stat, output mask, output irq);
endinterface : rxf_irq_if

// ### rtl/rxf_mem.sv
// Byte storage of the receive FIFO with a registered read port.
`timescale 1ns/1ps
module rxf_mem #(
    parameter int AW = 7
) (
    // Clock.
    input wire logic clk,
    // Write port.
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port, sampled every cycle.
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata_q
);
    // The storage array itself.
    logic [7:0] mem [0:(1<<AW)-1];

    // Writes land at once; a later read of the same word sees them.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Reading every cycle keeps the head byte fresh after a late write.
    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
    end
endmodule : rxf_mem

// ### rtl/rxf_irq.sv
// Sticky interrupt status, mask and interrupt level.
`timescale 1ns/1ps
module rxf_irq (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Link to the flag logic.
    rxf_irq_if.irq_side bus
);
    // Next values of status and mask.
    logic [rxf_pkg::N_EV-1:0] stat_d;
    logic [rxf_pkg::N_EV-1:0] mask_d;
    logic [rxf_pkg::N_EV-1:0] stat_q;
    logic [rxf_pkg::N_EV-1:0] mask_q;

    // A new event wins over a write-one-to-clear in the same cycle.
    assign stat_d = (stat_q & ~(bus.wr_stat ? bus.wdata : rxf_pkg::EV_RST)) | bus.ev;
    assign mask_d = bus.wr_mask ? bus.wdata : mask_q;

    // Status and mask registers.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_q <= rxf_pkg::EV_RST;
            mask_q <= rxf_pkg::EV_RST;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // Level output while any unmasked bit is set.
    assign bus.stat = stat_q;
    assign bus.mask = mask_q;
    assign bus.irq = |(stat_q & mask_q);
endmodule : rxf_irq

// ### rtl/rxf_top.sv
// Receive FIFO status flags with APB register access.
// What this block does
// - Flush flag works only with feature enabled.
// - Flush updates at start-of-frame, isochronous only.
// - Count sets; isochronous sets count at next frame.
// - Unreleased isochronous set discarded, flush flag set, with feature enabled.
// - Flush flag blocks data port read effects.
// - Writing release clears the flush flag.
// - Empty flag tracks current set live.
// - Full flag tracks current set live.
// - Underrun on empty read or count read with no set.
// - Only the clear control clears underrun.
// - Underrun leaves read pointer at empty.
// - Underrun makes the endpoint answer NAK.
// - Firmware effects immediate, isochronous traffic effects at frame.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module rxf_top #(
    parameter int FIFO_SIZE = rxf_pkg::FIFO_SIZE_DEF
) (
    // Clock and synchronous active-low reset.
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [rxf_pkg::AW-1:0] PADDR,
    input wire logic [rxf_pkg::DW-1:0] PWDATA,
    output logic [rxf_pkg::DW-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial interface engine side.
    input wire logic SIE_BYTE_VALID,
    input wire logic [7:0] SIE_BYTE,
    input wire logic SIE_SET_OK,
    input wire logic SIE_SOF,
    output logic RX_NAK,
    // Interrupt.
    output logic IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // Sizes.
    ////////////////////////////////////////////////////////////////////////

    // Pointers span two sets; FIFO_SIZE must be a power of two.
    localparam int W = $clog2(2 * FIFO_SIZE);
    localparam logic [W-1:0] SIZE_W = W'(FIFO_SIZE);
    localparam logic [W-1:0] PTR_ONE = W'(1);
    localparam logic [W-1:0] PTR_ZERO = W'(0);
    // Release and clear act once and must never read back as set.
    localparam int CW = rxf_pkg::CTRL_W;
    localparam logic [CW-1:0] CTRL_PULSE = CW'((1 << rxf_pkg::C_REL) | (1 << rxf_pkg::C_CLR));

    // Address match, used for every register select.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.
    ////////////////////////////////////////////////////////////////////////

    // Phases of a transfer; the slave never waits.
    logic setup;
    logic acc;
    logic rd_acc;
    logic wr_acc;
    assign setup = PSEL & ~PENABLE;
    assign acc = PSEL & PENABLE;
    assign rd_acc = acc & ~PWRITE;
    assign wr_acc = acc & PWRITE;

    // Register selects.
    logic sel_flags;
    logic sel_data;
    logic sel_cntl;
    logic sel_cnth;
    logic sel_ctrl;
    logic sel_istat;
    logic sel_imask;
    logic mapped;
    assign sel_flags = hit(PADDR, rxf_pkg::A_FLAGS);
    assign sel_data = hit(PADDR, rxf_pkg::A_DATA);
    assign sel_cntl = hit(PADDR, rxf_pkg::A_CNTL);
    assign sel_cnth = hit(PADDR, rxf_pkg::A_CNTH);
    assign sel_ctrl = hit(PADDR, rxf_pkg::A_CTRL);
    assign sel_istat = hit(PADDR, rxf_pkg::A_ISTAT);
    assign sel_imask = hit(PADDR, rxf_pkg::A_IMASK);
    assign mapped = sel_flags | sel_data | sel_cntl | sel_cnth | sel_ctrl | sel_istat | sel_imask;

    // Zero-wait answer; unmapped addresses report an error.
    assign PREADY = 1'b1;
    assign PSLVERR = acc & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // State.
    ////////////////////////////////////////////////////////////////////////

    logic [rxf_pkg::CTRL_W-1:0] ctrl_q; // Stored mode bits.
    logic [1:0] cnt_q; // Visible data sets.
    logic [1:0] cnt_d;
    logic [W-1:0] len0_q; // Length of the set being read.
    logic [W-1:0] len0_d;
    logic [W-1:0] len1_q; // Length of the next set.
    logic [W-1:0] len1_d;
    logic pend_q; // Isochronous set waiting for the frame.
    logic [W-1:0] plen_q; // Its length.
    logic [W-1:0] wlen_q; // Bytes of the set being written.
    logic [W-1:0] wr_ptr_q;
    logic [W-1:0] rd_ptr_q;
    logic [W-1:0] rd_ptr_d;
    logic [W-1:0] base_q; // First byte of the set being read.
    logic flush_q;
    logic urf_q;
    logic ovf_q;
    logic ovf_pend_q; // Isochronous overrun waiting for the frame.
    logic [7:0] head_byte;
    logic [rxf_pkg::DW-1:0] prdata_q;

    // Mode bits.
    logic iso;
    logic feat;
    assign iso = ctrl_q[rxf_pkg::C_ISO];
    assign feat = ctrl_q[rxf_pkg::C_FEAT];

    // Pulses written by firmware.
    logic rel_p;
    logic clr_p;
    assign rel_p = wr_acc & sel_ctrl & PWDATA[rxf_pkg::C_REL];
    assign clr_p = wr_acc & sel_ctrl & PWDATA[rxf_pkg::C_CLR];

    ////////////////////////////////////////////////////////////////////////
    // Live flags.
    ////////////////////////////////////////////////////////////////////////

    // Bytes already taken from the current set.
    logic [W-1:0] used;
    logic empty_w;
    logic full_w;
    logic no_set;
    assign used = rd_ptr_q - base_q;
    assign no_set = (cnt_q == rxf_pkg::CNT_ZERO);
    assign empty_w = no_set | (used == len0_q);
    assign full_w = ~no_set & (len0_q == SIZE_W);

    // Host traffic is refused while an error flag stands.
    assign RX_NAK = urf_q | ovf_q;

    ////////////////////////////////////////////////////////////////////////
    // Set accounting.
    ////////////////////////////////////////////////////////////////////////

    // A release with the flush flag up only clears the flag: the set is gone.
    logic rel_pop;
    logic sof_iso;
    logic stale;
    logic set_pop;
    assign rel_pop = rel_p & ~flush_q & ~no_set;
    assign sof_iso = SIE_SOF & iso;
    // A release in the same cycle as the frame mark saves the set.
    assign stale = sof_iso & feat & ~no_set & ~rel_pop;

    assign set_pop = rel_pop | stale;

    // Sets held, counting one waiting for the frame.
    logic [1:0] held;
    logic sie_block;
    logic byte_ok;
    logic byte_ovf;
    assign held = cnt_q + {1'b0, pend_q};
    assign sie_block = (wlen_q == SIZE_W) | (held == rxf_pkg::CNT_MAX);
    assign byte_ok = SIE_BYTE_VALID & ~RX_NAK & ~sie_block;
    assign byte_ovf = SIE_BYTE_VALID & ~RX_NAK & sie_block;

    // A completed set counts now, or at the next frame when isochronous.
    logic set_ok;
    logic now_push;
    logic frame_push;
    logic set_push;
    logic [W-1:0] new_len;
    assign set_ok = SIE_SET_OK & ~RX_NAK & ~ovf_pend_q;
    assign now_push = set_ok & ~iso;
    assign frame_push = sof_iso & pend_q;
    assign set_push = now_push | frame_push;
    assign new_len = frame_push ? plen_q : wlen_q;

    // Data port reads have no effect while a flush stands.
    logic data_rd;
    logic byte_pop;
    logic urf_ev;
    assign data_rd = rd_acc & sel_data & ~flush_q;
    assign byte_pop = data_rd & ~empty_w;
    // Firmware caused, so it is never deferred to the frame.
    assign urf_ev = (data_rd & empty_w) | (rd_acc & (sel_cntl | sel_cnth) & no_set);

    // Next set queue: the pop shifts, the push lands behind it.
    always_comb begin
        cnt_d = cnt_q;
        len0_d = len0_q;
        len1_d = len1_q;
        if (clr_p) begin
            cnt_d = rxf_pkg::CNT_ZERO;
            len0_d = PTR_ZERO;
            len1_d = PTR_ZERO;
        end else begin
            if (set_pop) begin
                len0_d = len1_q;
                cnt_d = cnt_q - rxf_pkg::CNT_ONE;
            end
            if (set_push) begin
                if (cnt_d == rxf_pkg::CNT_ZERO) begin
                    len0_d = new_len;
                end else begin
                    len1_d = new_len;
                end
                cnt_d = cnt_d + rxf_pkg::CNT_ONE;
            end
        end
    end

    // Read pointer: a discarded or released set moves it to the next set.
    logic [W-1:0] next_base;
    assign next_base = base_q + len0_q;
    assign rd_ptr_d = clr_p ? PTR_ZERO : set_pop ? next_base : byte_pop ? rd_ptr_q + PTR_ONE : rd_ptr_q;

    // Set queue and pointer registers.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            cnt_q <= rxf_pkg::CNT_ZERO;
            len0_q <= PTR_ZERO;
            len1_q <= PTR_ZERO;
            rd_ptr_q <= PTR_ZERO;
            base_q <= PTR_ZERO;
        end else begin
            cnt_q <= cnt_d;
            len0_q <= len0_d;
            len1_q <= len1_d;
            rd_ptr_q <= rd_ptr_d;
            base_q <= clr_p ? PTR_ZERO : set_pop ? next_base : base_q;
        end
    end

    // Write side: pointer, running length and the waiting set.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || clr_p) begin
            wr_ptr_q <= PTR_ZERO;
            wlen_q <= PTR_ZERO;
            pend_q <= 1'b0;
            plen_q <= PTR_ZERO;
        end else begin
            wr_ptr_q <= byte_ok ? wr_ptr_q + PTR_ONE : wr_ptr_q;
            wlen_q <= SIE_SET_OK ? PTR_ZERO : byte_ok ? wlen_q + PTR_ONE : wlen_q;
            // A new set is caught in the same frame that frees the slot.
            pend_q <= (set_ok & iso) | (pend_q & ~sof_iso);
            plen_q <= (set_ok & iso) ? wlen_q : plen_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error and flush flags.
    ////////////////////////////////////////////////////////////////////////

    // Flush is set at the frame mark; a release clears it, but set wins.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || clr_p) begin
            flush_q <= 1'b0;
        end else if (stale) begin
            flush_q <= 1'b1;
        end else if (rel_p) begin
            flush_q <= 1'b0;
        end
    end

    // Underrun sticks until the clear control; overrun waits for the frame when isochronous.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || clr_p) begin
            urf_q <= 1'b0;
            ovf_q <= 1'b0;
            ovf_pend_q <= 1'b0;
        end else begin
            urf_q <= urf_q | urf_ev;
            ovf_pend_q <= (ovf_pend_q & ~sof_iso) | (byte_ovf & iso);
            ovf_q <= ovf_q | (byte_ovf & ~iso) | (ovf_pend_q & sof_iso);
        end
    end

    // Mode bits; the pulse bits are not stored.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            ctrl_q <= rxf_pkg::CTRL_RST;
        end else if (wr_acc && sel_ctrl) begin
            ctrl_q <= PWDATA[rxf_pkg::CTRL_W-1:0] & ~CTRL_PULSE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage and interrupts.
    ////////////////////////////////////////////////////////////////////////

    // Read address is the next pointer so the head byte is ready in setup.
    rxf_mem #(.AW(W)) u_mem (
        .clk(SYS_CLK),
        .we(byte_ok),
        .waddr(wr_ptr_q),
        .wdata(SIE_BYTE),
        .raddr(rd_ptr_d),
        .rdata_q(head_byte)
    );

    rxf_irq_if irq_bus ();
    assign irq_bus.ev[rxf_pkg::E_SET] = set_push & ~clr_p;
    assign irq_bus.ev[rxf_pkg::E_FLUSH] = stale & ~clr_p;
    assign irq_bus.ev[rxf_pkg::E_URF] = urf_ev;
    assign irq_bus.wr_stat = wr_acc & sel_istat;
    assign irq_bus.wr_mask = wr_acc & sel_imask;
    assign irq_bus.wdata = PWDATA[rxf_pkg::N_EV-1:0];

    rxf_irq u_irq (
        .clk(SYS_CLK),
        .rst_b(RST_B),
        .bus(irq_bus)
    );
    assign IRQ = irq_bus.irq;

    ////////////////////////////////////////////////////////////////////////
    // Read data.
    ////////////////////////////////////////////////////////////////////////

    // Flag byte; bit 5 reads zero and flush reads zero without the feature.
    logic [7:0] flags_w;
    assign flags_w = {cnt_q, 1'b0, flush_q & feat, empty_w, full_w, urf_q, ovf_q};

    // Byte count of the current set, zero when no set is visible.
    logic [15:0] bcnt;
    assign bcnt = no_set ? 16'h0000 : 16'(len0_q);

    // Read mux; unmapped addresses read zero.
    logic [7:0] rd_mux;
    assign rd_mux = sel_flags ? flags_w :
        sel_data ? head_byte :
        sel_cntl ? bcnt[7:0] :
        sel_cnth ? bcnt[15:8] :
        sel_ctrl ? {4'h0, ctrl_q} :
        sel_istat ? {5'h00, irq_bus.stat} :
        sel_imask ? {5'h00, irq_bus.mask} : 8'h00;

    // Captured in setup so reads see state before their own side effect.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !PWRITE) begin
            prdata_q <= {24'h000000, rd_mux};
        end
    end
    assign PRDATA = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    flush_gate_a: assert property (!feat |-> !flags_w[rxf_pkg::B_FLUSH])
        else $error("flush flag visible without feature");
    flush_sof_a: assert property ($rose(flush_q) |-> $past(SIE_SOF) && $past(iso))
        else $error("flush flag rose outside an isochronous frame mark");
    iso_defer_a: assert property ((iso && !SIE_SOF && !clr_p) |=> cnt_q <= $past(cnt_q))
        else $error("isochronous set counted before the frame mark");
    stale_drop_a: assert property ((stale && !clr_p && !pend_q) |=> flush_q && cnt_q == $past(cnt_d))
        else $error("stale set not discarded");
    flush_block_a: assert property ((flush_q && rd_acc && sel_data && !SIE_SOF) |=> $stable(rd_ptr_q))
        else $error("data read moved pointer during flush");
    rel_clear_a: assert property ((rel_p && !SIE_SOF) |=> !flush_q ##1 !flush_q || $past(SIE_SOF))
        else $error("release did not clear flush");
    empty_live_a: assert property (no_set |-> flags_w[rxf_pkg::B_EMP] && !flags_w[rxf_pkg::B_FULL])
        else $error("empty flag wrong with no set");
    full_live_a: assert property ((!no_set && len0_q == SIZE_W && used == PTR_ZERO) |-> full_w && !empty_w)
        else $error("full flag wrong for full set");
    urf_set_a: assert property ((rd_acc && (sel_cntl || sel_cnth) && no_set && !clr_p) |=> urf_q)
        else $error("count read with no set did not underrun");
    urf_hold_a: assert property ((urf_q && !clr_p) |=> urf_q [*2] or (urf_q ##1 $past(clr_p)))
        else $error("underrun cleared without clear control");
    urf_ptr_a: assert property ((rd_acc && sel_data && empty_w && !SIE_SOF) |=> $stable(rd_ptr_q))
        else $error("read pointer left empty position");
    nak_a: assert property (urf_q |-> RX_NAK && !byte_ok)
        else $error("traffic accepted during underrun");
    urf_now_a: assert property ((iso && data_rd && empty_w) |=> urf_q)
        else $error("isochronous underrun deferred");
    cnt_dec_a: assert property ((rel_pop && !set_push && !clr_p) |=> cnt_q == $past(cnt_q) - rxf_pkg::CNT_ONE)
        else $error("release did not decrement set count");

    set_seen_c: cover property (set_push ##[1:20] rel_pop);
    flush_seen_c: cover property (stale ##[1:20] rel_p);
    urf_seen_c: cover property (urf_ev ##[1:20] clr_p);
endmodule : rxf_top

// ### bench/rxf_fw.sv
// Firmware model: an APB master that reads data sets out of the receive FIFO.
`timescale 1ns/1ps
module rxf_fw (
    // Clock.
    input wire logic clk,
    // APB master side.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [rxf_pkg::AW-1:0] paddr,
    output logic [rxf_pkg::DW-1:0] pwdata,
    input wire logic [rxf_pkg::DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Stored control bits, resent with every release so mode bits survive.
    logic [31:0] ctrl_v = 32'h0;
    // Error response seen at the end of the last transfer.
    logic last_err = 1'b0;
    // Idle bus at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One transfer; the request is held until pready is seen high at an edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released data bus shows no stale value.
        pwdata <= ~d;
    endtask : xfer
    ////////////////////////////////////////////////////////////////////////////
    // Reads n bytes, reads the flags before releasing, and always releases.
    task automatic take_set(input int n, output logic [7:0] q[$], output logic [31:0] f);
        logic [31:0] r;
        q = {};
        for (int i = 0; i < n; i++) begin
            xfer(1'b0, rxf_pkg::A_DATA, 32'h0, r);
            q.push_back(r[7:0]);
        end
        xfer(1'b0, rxf_pkg::A_FLAGS, 32'h0, f);
        xfer(1'b1, rxf_pkg::A_CTRL, ctrl_v | 32'h1, r);
    endtask : take_set
endmodule : rxf_fw

// ### bench/test_usb_rx_fifo_status_flags.sv
// Self-checking testbench for the receive FIFO status flags.
`timescale 1ns/1ps
module test_usb_rx_fifo_status_flags;
    // Small set size keeps the full case short.
    localparam int FS = 8;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, nak, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, f;
    logic sv = 1'b0, sok = 1'b0, sof_p = 1'b0;
    logic [7:0] sb = 8'h00;
    logic [7:0] q[$];
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    rxf_top #(.FIFO_SIZE(FS)) DUT (.SYS_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SIE_BYTE_VALID(sv), .SIE_BYTE(sb), .SIE_SET_OK(sok), .SIE_SOF(sof_p),
        .RX_NAK(nak), .IRQ(irq));
    rxf_fw fw (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Clock, 5 ns period.
    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run.
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    // A hang is cut short well past the expected run length.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    // Compares one value with case equality.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            n_mismatch++;
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        fw.xfer(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        fw.xfer(1'b1, a, d, r);
    endtask : wr
    // Serial engine delivers n bytes, then marks the set valid after one idle cycle.
    task automatic send(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            sv <= 1'b1;
            sb <= base + 8'(i);
        end
        @(posedge clk);
        sv <= 1'b0;
        @(posedge clk);
        sok <= 1'b1;
        @(posedge clk);
        sok <= 1'b0;
    endtask : send
    task automatic sof();
        @(posedge clk);
        sof_p <= 1'b1;
        @(posedge clk);
        sof_p <= 1'b0;
    endtask : sof
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(rxf_pkg::A_FLAGS, 32'h08, "reset flags");
        // Plain set of four bytes; count rises, empty drops.
        send(4, 8'ha0);
        rd(rxf_pkg::A_FLAGS, 32'h40, "one set");
        fw.take_set(4, q, f);
        for (int i = 0; i < 4; i++) chk("data byte", 32'(8'ha0 + 8'(i)), 32'(q[i]));
        rd(rxf_pkg::A_FLAGS, 32'h08, "after release");
        // Set exactly the FIFO size.
        send(FS, 8'h10);
        rd(rxf_pkg::A_FLAGS, 32'h44, "full set");
        fw.take_set(FS, q, f);
        rd(rxf_pkg::A_FLAGS, 32'h08, "full released");
        // Count read with no set held, interrupt unmasked.
        wr(rxf_pkg::A_IMASK, 32'h4);
        rd(rxf_pkg::A_CNTL, 32'h0, "count low");
        rd(rxf_pkg::A_FLAGS, 32'h0a, "count underrun");
        rd(rxf_pkg::A_ISTAT, 32'h5, "irq status");
        chk("nak", 32'h1, 32'(nak));
        chk("irq", 32'h1, 32'(irq));
        wr(rxf_pkg::A_CTRL, 32'h0);
        rd(rxf_pkg::A_FLAGS, 32'h0a, "underrun sticky");
        wr(rxf_pkg::A_CTRL, 32'h2);
        wr(rxf_pkg::A_ISTAT, 32'h7);
        rd(rxf_pkg::A_FLAGS, 32'h08, "cleared");
        chk("irq off", 32'h0, 32'(irq));
        chk("nak off", 32'h0, 32'(nak));
        // Data port read from an empty FIFO.
        rd(rxf_pkg::A_CNTH, 32'h0, "count high");
        wr(rxf_pkg::A_CTRL, 32'h2);
        fw.xfer(1'b0, rxf_pkg::A_DATA, 32'h0, r);
        rd(rxf_pkg::A_FLAGS, 32'h0a, "pop underrun");
        wr(rxf_pkg::A_CTRL, 32'h2);
        // Unmapped address answers with an error and zero data.
        rd(8'h1c, 32'h0, "unmapped data");
        chk("unmapped err", 32'h1, 32'(fw.last_err));
        // Isochronous, late firmware: without the feature the late set stays, with it the set is flushed.
        for (int k = 0; k < 2; k++) begin
            fw.ctrl_v = (k == 1) ? 32'hc : 32'h4;
            wr(rxf_pkg::A_CTRL, fw.ctrl_v);
            send(2, 8'h50);
            rd(rxf_pkg::A_FLAGS, 32'h08, "iso deferred");
            sof();
            rd(rxf_pkg::A_FLAGS, 32'h40, "iso visible");
            sof();
            rd(rxf_pkg::A_FLAGS, (k == 1) ? 32'h18 : 32'h40, "iso stale");
            fw.take_set(2, q, f);
            chk("late read flags", (k == 1) ? 32'h18 : 32'h48, f);
            // Without a flush an extra data read underruns at once, even when isochronous.
            if (k == 0) fw.xfer(1'b0, rxf_pkg::A_DATA, 32'h0, r);
            rd(rxf_pkg::A_FLAGS, (k == 1) ? 32'h08 : 32'h0a, "iso release");
            wr(rxf_pkg::A_CTRL, fw.ctrl_v | 32'h2);
            rd(rxf_pkg::A_CTRL, fw.ctrl_v, "ctrl readback");
        end
        final_report();
    end
endmodule : test_usb_rx_fifo_status_flags
